// >>> src/crcacc_top.sv
// CRC-16 byte accumulator with an AXI4-Lite register slave
// Notes on behaviour
// - CRC-16 with polynomial x16+x12+x5+1
// - Messages of any length, whole bytes
// - Each byte write folds into remainder
// - Byte input register 8 bits, resets 00H
// - Result register 16 bits, resets 0000H
// - Remainder of reversed message times x16
// - Bits LSB first, result reflected order
// - Feeding received code leaves 0000H
`include "crcacc_params.svh"
`default_nettype none
module crcacc_top #(
  parameter int FIFO_DEPTH = `CRCACC_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Write address channel
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address channel
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import crcacc_pkg::*;

  // One reflected CRC-CCITT step per byte, LSB first
  function automatic logic [15:0] crcStep(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++)
    begin
      if (c[0] ^ data[i])
      begin
        c = (c >> 1) ^ `CRCACC_POLY_REFLECTED;
      end
      else
      begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

  // Registers sit on word boundaries; the two low address bits are ignored
  function automatic logic [3:0] wordAddr(input logic [3:0] addr);
    return {addr[3:2], 2'b00};
  endfunction

  logic [7:0] byteInput_q;
  logic [15:0] result_q;
  // Write and read sides keep separate handshake states
  crcacc_bus_state_t wrState_q;
  crcacc_bus_state_t rdState_q;
  // Write beats parked until the address and data pair is complete
  logic awHeld_q;
  logic wHeld_q;
  logic [3:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  // Queue between the register bus and the fold engine
  logic fifoInValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic [7:0] fifoOutData;
  logic wrGo;
  logic hitByte;
  logic hitResult;
  logic byteOk;
  logic resultOk;
  logic busy;

  // A write goes ahead once both its address and its data are held
  assign wrGo = (wrState_q == CRCACC_IDLE) && awHeld_q && wHeld_q;
  assign hitByte = (awAddr_q == `CRCACC_OFS_BYTE_INPUT);
  assign hitResult = (awAddr_q == `CRCACC_OFS_RESULT);
  // Byte write needs lane 0; result write needs both low lanes
  assign byteOk = hitByte && wStrb_q[0];
  assign resultOk = hitResult && (wStrb_q[1:0] == 2'b11);
  assign fifoInValid = wrGo && byteOk;
  // Bytes queued or being folded hold off reads and seeds
  assign busy = fifoOutValid;

  // Writes stall while the FIFO is full or the engine still owes bytes to a seed
  logic wrStall;
  assign wrStall = (byteOk && !fifoInReady) || (resultOk && busy);

  // The engine drains a byte every cycle; the queue fills only if writes outpace it
  crcacc_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .reset(reset),
    .inValid(fifoInValid && !wrStall),
    .inReady(fifoInReady),
    .inData(wData_q[7:0]),
    .outValid(fifoOutValid),
    .outReady(1'b1),
    .outData(fifoOutData)
  );

  // Ready pulses on alternate cycles while a channel waits, so each beat is taken once
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !awHeld_q && !s_axi_awready && (wrState_q == CRCACC_IDLE);
      s_axi_wready <= !wHeld_q && !s_axi_wready && (wrState_q == CRCACC_IDLE);
    end
  end

  // Address and data captured in either order
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= wordAddr(s_axi_awaddr);
      end
      else if (wrGo && !wrStall)
      begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      else if (wrGo && !wrStall)
      begin
        wHeld_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wrState_q <= CRCACC_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CRCACC_RESP_OKAY;
    end
    else
    begin
      // Unmapped words and short strobes answer SLVERR and store nothing
      case (wrState_q)
        CRCACC_IDLE:
        begin
          if (wrGo && !wrStall)
          begin
            wrState_q <= CRCACC_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (byteOk || resultOk) ? `CRCACC_RESP_OKAY : `CRCACC_RESP_SLVERR;
          end
        end
        CRCACC_RESP:
        begin
          if (s_axi_bready)
          begin
            wrState_q <= CRCACC_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default:
        begin
          wrState_q <= CRCACC_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Byte input register keeps the last byte written
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      byteInput_q <= `CRCACC_BYTE_RESET;
    end
    else if (fifoInValid && !wrStall)
    begin
      byteInput_q <= wData_q[7:0];
    end
  end

  // Running remainder: seed write or one byte per cycle from the FIFO
  // A seed waits for an empty queue, so it never meets a fold in one cycle
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      result_q <= `CRCACC_RESULT_RESET;
    end
    else if (wrGo && !wrStall && resultOk)
    begin
      result_q <= wData_q[15:0];
    end
    else if (fifoOutValid)
    begin
      result_q <= crcStep(result_q, fifoOutData);
    end
  end

  // Read word decoded from the live address; an unmapped word answers zero with an error
  logic [31:0] rdWord;
  logic rdHit;
  always_comb
  begin
    rdWord = '0;
    rdHit = 1'b1;
    case (wordAddr(s_axi_araddr))
      `CRCACC_OFS_BYTE_INPUT: rdWord = {24'h00_0000, byteInput_q};
      `CRCACC_OFS_RESULT: rdWord = {16'h0000, result_q};
      `CRCACC_OFS_STATUS: rdWord = {31'h0000_0000, busy};
      default: rdHit = 1'b0;
    endcase
  end

  // Reads wait until every queued byte has been folded in
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rdState_q <= CRCACC_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `CRCACC_RESP_OKAY;
    end
    else
    begin
      case (rdState_q)
        CRCACC_IDLE:
        begin
          // Held off while a byte is entering or still queued, so the result is current
          s_axi_arready <= !s_axi_arready && !busy && !fifoInValid;
          if (s_axi_arvalid && s_axi_arready)
          begin
            rdState_q <= CRCACC_RESP;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdWord;
            s_axi_rresp <= rdHit ? `CRCACC_RESP_OKAY : `CRCACC_RESP_SLVERR;
          end
        end
        CRCACC_RESP:
        begin
          if (s_axi_rready)
          begin
            rdState_q <= CRCACC_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default:
        begin
          rdState_q <= CRCACC_IDLE;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> src/crcacc_params.svh
// Constants for the CRC-16 byte accumulator
`ifndef CRCACC_PARAMS_SVH
`define CRCACC_PARAMS_SVH
`define CRCACC_OFS_BYTE_INPUT 4'h0
`define CRCACC_OFS_RESULT 4'h4
`define CRCACC_OFS_STATUS 4'h8
`define CRCACC_POLY_REFLECTED 16'h8408
`define CRCACC_BYTE_RESET 8'h00
`define CRCACC_RESULT_RESET 16'h0000
`define CRCACC_RESP_OKAY 2'b00
`define CRCACC_RESP_SLVERR 2'b10
`define CRCACC_FIFO_DEPTH 32
`endif

// >>> src/crcacc_pkg.sv
// Types for the CRC-16 byte accumulator
`default_nettype none
package crcacc_pkg;
  typedef enum logic [1:0] {CRCACC_IDLE, CRCACC_RESP} crcacc_bus_state_t;
endpackage
`default_nettype wire

// >>> src/crcacc_fifo.sv
// Byte FIFO between the register bus and the CRC engine
`default_nettype none
module crcacc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic outValid_q;
  logic [WIDTH-1:0] outData_q;
  logic [AW:0] memCount;
  logic push;
  logic pop;
  logic regFree;
  logic memPop;
  logic bypass;
  // The count covers the output register as well as the words left in memory
  assign memCount = count_q - {{AW{1'b0}}, outValid_q};
  assign inReady = (count_q != (AW + 1)'(DEPTH));
  assign outValid = outValid_q;
  assign outData = outData_q;
  assign push = inValid && inReady;
  assign pop = outValid_q && outReady;
  // The output register reloads whenever it is empty or being drained
  assign regFree = !outValid_q || pop;
  assign memPop = regFree && (memCount != '0);
  // With nothing queued a new word skips the memory, keeping a one-cycle latency
  assign bypass = regFree && (memCount == '0) && push;
  always_ff @(posedge clock)
  begin
    if (push && !bypass)
    begin
      mem[wrPtr_q] <= inData;
    end
  end
  // Read data leave the memory through a register
  always_ff @(posedge clock)
  begin
    if (memPop)
    begin
      outData_q <= mem[rdPtr_q];
    end
    else if (bypass)
    begin
      outData_q <= inData;
    end
  end
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      outValid_q <= 1'b0;
    end
    else
    begin
      if (push && !bypass)
      begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (memPop)
      begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
      if (regFree)
      begin
        outValid_q <= memPop || push;
      end
      if (push && !pop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/crcacc_sva.sv
// Bus timing checks for the CRC-16 byte accumulator
`default_nettype none
module crcacc_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Write handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  rst_idle_a: assert property ($fell(reset) |-> !s_axi_bvalid && !s_axi_rvalid)
    else $error("bus answer pending right after reset");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late after address taken");
  rd_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after handshake");
  rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data has bits above the result width");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:8] s_axi_bvalid)
    else $error("write response late");
  wr_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after handshake");
  ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("read address ready held two cycles");
  rd_single_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken while one is open");
endmodule
bind crcacc_top crcacc_sva u_crcacc_sva (.clock(clock), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the CRC-16 byte accumulator
`include "crcacc_params.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'h0;
  logic reset = 1'h1;
  logic [3:0] awAddr = 4'h0, wStrb = 4'h0, arAddr = 4'h0;
  logic [31:0] wData = 32'h0000_0000;
  logic awValid = 1'h0, wValid = 1'h0, bReady = 1'h0, arValid = 1'h0, rReady = 1'h0;
  logic awReady, wReady, bValid, arReady, rValid;
  logic [1:0] bResp, rResp;
  logic [31:0] rData;
  logic [15:0] crcExp, sent;
  int numErrors = 0;
  int nCompared = 0;
  // One steady clock, so result accesses never meet a slow clock
  always #25 clock = ~clock;
  crcacc_top u_crcacc_top (.clock(clock), .reset(reset), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tally_and_finish();
    $display("compared %0d mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Reflected CRC-CCITT step, one byte, low bit first
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    return c;
  endfunction
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge clock);
    awAddr <= a;
    wData <= d;
    wStrb <= s;
    awValid <= 1'h1;
    wValid <= 1'h1;
    bReady <= 1'h1;
    forever
    begin
      @(posedge clock);
      if (awReady)
        awValid <= 1'h0;
      if (wReady)
        wValid <= 1'h0;
      if (bValid)
        break;
    end
    bReady <= 1'h0;
    check("bresp", {30'h0000_0000, bResp}, {30'h0000_0000, er});
  endtask
  task rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock);
    arAddr <= a;
    arValid <= 1'h1;
    rReady <= 1'h1;
    forever
    begin
      @(posedge clock);
      if (arReady)
        arValid <= 1'h0;
      if (rValid)
        break;
    end
    rReady <= 1'h0;
    check("rdata", rData, ed);
    check("rresp", {30'h0000_0000, rResp}, {30'h0000_0000, er});
  endtask
  task fb(input logic [7:0] b);
    wr(4'h0, {24'h00_0000, b}, 4'h1, `CRCACC_RESP_OKAY);
    crcExp = crcStep(crcExp, b);
  endtask
  initial
  begin
    repeat (3) @(posedge clock);
    reset <= 1'h0;
    rd(4'h0, 32'h0000_0000, `CRCACC_RESP_OKAY);
    rd(4'h4, 32'h0000_0000, `CRCACC_RESP_OKAY);
    wr(4'h4, 32'h0000_0000, 4'hF, `CRCACC_RESP_OKAY);
    crcExp = 16'h0000;
    fb(8'h01);
    rd(4'h4, 32'h0000_1189, `CRCACC_RESP_OKAY);
    rd(4'h0, 32'h0000_0001, `CRCACC_RESP_OKAY);
    wr(4'h4, 32'h0000_0000, 4'h3, `CRCACC_RESP_OKAY);
    crcExp = 16'h0000;
    for (int i = 0; i < 4; i++)
      fb(8'h12 + 8'h22 * i[7:0]);
    rd(4'h4, {16'h0000, crcExp}, `CRCACC_RESP_OKAY);
    sent = crcExp;
    fb(sent[7:0]);
    fb(sent[15:8]);
    rd(4'h4, 32'h0000_0000, `CRCACC_RESP_OKAY);
    wr(4'h4, 32'h0000_ABCD, 4'h3, `CRCACC_RESP_OKAY);
    wr(4'h4, 32'h0000_1234, 4'h1, `CRCACC_RESP_SLVERR);
    rd(4'h4, 32'h0000_ABCD, `CRCACC_RESP_OKAY);
    crcExp = 16'hABCD;
    for (int i = 0; i < 40; i++)
      fb(i[7:0] ^ 8'hA5);
    rd(4'h4, {16'h0000, crcExp}, `CRCACC_RESP_OKAY);
    rd(4'hC, 32'h0000_0000, `CRCACC_RESP_SLVERR);
    rd(4'h8, 32'h0000_0000, `CRCACC_RESP_OKAY);
    tally_and_finish();
  end
  // Cuts a hung handshake short
  initial
  begin
    repeat (20000) @(posedge clock);
    numErrors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
